// ==== xmem_pkg.sv ====
/*
 * package for the external data memory router and strobe sequencer:
 * register map, field layouts, reset values, mode codes, bus carriers.
 * assumes an ahb-lite register bus with 32-bit data and one system clock.
 */
package xmem_pkg;

    // register byte addresses
    localparam logic [7:0]  timing_ctrl_addr   = 8'h00;
    localparam logic [7:0]  config_addr        = 8'h04;
    localparam logic [7:0]  page_select_addr   = 8'h08;
    localparam logic [7:0]  status_addr        = 8'h0C;

    localparam logic [7:0]  timing_ctrl_reset  = 8'hFF;
    localparam logic [5:0]  config_reset       = 6'h03;
    localparam logic [7:0]  page_select_reset  = 8'h00;

    // field positions
    localparam int          setup_hi           = 7;
    localparam int          setup_lo           = 6;
    localparam int          strobe_hi          = 5;
    localparam int          strobe_lo          = 2;
    localparam int          hold_hi            = 1;
    localparam int          hold_lo            = 0;
    localparam int          port_enable_bit    = 5;
    localparam int          mux_select_bit     = 4;
    localparam int          mode_hi            = 3;
    localparam int          mode_lo            = 2;
    localparam int          ale_hi             = 1;
    localparam int          ale_lo             = 0;

    // on-chip ram covers 4 kB; above that space wraps or goes off-chip
    localparam int          onchip_addr_bits   = 12;
    localparam logic [3:0]  onchip_page_top    = 4'h0;

    // fixed overhead cycles of an off-chip move beyond the programmed fields
    localparam logic [5:0]  fixed_overhead     = 6'h04;
    localparam logic [4:0]  one_cycle          = 5'h01;

    typedef enum logic [1:0] {
        mode_internal_only = 2'b00,
        mode_split_no_bank = 2'b01,
        mode_split_bank    = 2'b10,
        mode_external_only = 2'b11
    } operating_mode_t;

    // gray codes along the path idle-setup-ale_hi-ale_lo-strobe-hold-tail
    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_setup  = 3'b001,
        st_ale_hi = 3'b011,
        st_ale_lo = 3'b010,
        st_strobe = 3'b110,
        st_hold   = 3'b111,
        st_tail   = 3'b101,
        st_onchip = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic        is_write;
        logic        wide_pointer;
        logic [15:0] data_pointer;
        logic [7:0]  index;
        logic [7:0]  wdata;
    } move_req_t;

    typedef struct packed {
        logic [15:0] addr_out;
        logic [15:0] addr_oe;
        logic [7:0]  data_out;
        logic        data_oe;
        logic        rd_b;
        logic        wr_b;
        logic        ale;
        logic        ctrl_oe;
    } ext_pins_t;

endpackage

// ==== xmem_ctrl.sv ====
/*
 * external data move router and off-chip strobe sequencer.
 * the cpu core issues one move at a time on move_valid and waits for
 * move_done; off-chip memory is asynchronous and sampled through two flops.
 */
//
// Overview of operation
// - mode 00 sends every move on-chip, no off-chip cycle.
// - internal-only mode folds addresses onto on-chip ram every 4 kB.
// - internal-only 8-bit pointer: high byte page-select, low byte index.
// - 16-bit pointer access uses the full data pointer as address.
// - split modes: below 4 kB on-chip, at or above off-chip.
// - split modes: 8-bit pointer routing decided by page-select contents.
// - split without bank: 8-bit off-chip leaves A15..8 undriven, A7..0 index.
// - split modes: 16-bit pointer routes by pointer, drives all sixteen lines.
// - split with bank: 8-bit off-chip drives page-select high, index low.
// - mode 11 sends every move off-chip; on-chip ram invisible.
// - external-only 8-bit: ignore page-select, upper undriven, lower index.
// - external-only 16-bit drives all sixteen lines from data pointer.
// - setup, hold, strobe and latch widths programmable in clocks.
// - off-chip move lasts fields plus 5 clocks, minimum 6.
// - multiplexed mode adds at least 2 latch clocks, minimum 8.
// - timing register resets to all ones.
// - bits 7-6 setup, bits 1-0 hold, each 0 to 3 clocks.
// - bits 5-2 strobe width equals field plus one clocks.
// - non-multiplexed when multiplex select bit set.
// - latch high and low phases each 1 to 4 clocks, multiplexed only.
// - multiplexed: low address on data pins while latch enable high.
// - pins claimed only during off-chip move, released after.
`timescale 1ns/10ps
`default_nettype none

module xmem_ctrl
    import xmem_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // cpu move request
    input  wire logic        move_valid,
    input  wire move_req_t   move_req,
    output logic             move_done,
    output logic      [7:0]  move_rdata,
    // on-chip ram port
    output logic             ram_en,
    output logic             ram_we,
    output logic      [11:0] ram_addr,
    output logic      [7:0]  ram_wdata,
    input  wire logic [7:0]  ram_rdata,
    // external pins
    output ext_pins_t        pins,
    input  wire logic [7:0]  ext_data_in
);

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0]  timing_q, timing_d;
    logic [5:0]  config_q, config_d;
    logic [7:0]  page_q, page_d;
    logic        wr_pend_q, wr_pend_d;
    logic [7:0]  wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        busy;

    function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [7:0] t,
                                             input logic [5:0] c, input logic [7:0] p,
                                             input logic b);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            timing_ctrl_addr: v = {24'h00_0000, t};
            config_addr:      v = {26'h000_0000, c};
            page_select_addr: v = {24'h00_0000, p};
            status_addr:      v = {31'h0000_0000, b};
            default:          v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    always_comb begin
        timing_d  = timing_q;
        config_d  = config_q;
        page_d    = page_q;
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        hrdata_d  = hrdata_q;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                timing_ctrl_addr: timing_d = hwdata[7:0];
                config_addr:      config_d = hwdata[5:0];
                page_select_addr: page_d   = hwdata[7:0];
                default:          ;
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            wr_pend_d = hwrite;
            wr_addr_d = haddr[7:0];
            hrdata_d  = reg_read(haddr[7:0], timing_d, config_d, page_d, busy);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timing_q  <= timing_ctrl_reset;
            config_q  <= config_reset;
            page_q    <= page_select_reset;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            timing_q  <= timing_d;
            config_q  <= config_d;
            page_q    <= page_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q  <= hrdata_d;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ************************************************************
    // address routing
    // ************************************************************
    operating_mode_t mode;
    logic [15:0] eff_addr;
    logic        go_offchip;
    logic        drive_upper;
    logic        multiplexed;

    assign mode        = operating_mode_t'(config_q[mode_hi:mode_lo]);
    assign multiplexed = ~config_q[mux_select_bit];

    always_comb begin
        // 8-bit form: page-select supplies the high byte for routing
        eff_addr = move_req.wide_pointer ? move_req.data_pointer
                                         : {page_q, move_req.index};
        unique case (mode)
            mode_internal_only: go_offchip = 1'b0;
            mode_external_only: go_offchip = 1'b1;
            default:            go_offchip = (eff_addr[15:onchip_addr_bits] != onchip_page_top);
        endcase
        // upper lines only in bank mode or for the 16-bit form
        drive_upper = move_req.wide_pointer || (mode == mode_split_bank);
    end

    // ************************************************************
    // strobe sequencer
    // ************************************************************
    seq_state_t  state_q, state_d;
    logic [4:0]  cnt_q, cnt_d;
    move_req_t   req_q, req_d;
    logic        upper_q, upper_d;
    logic        mux_q, mux_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        done_q, done_d;
    logic [7:0]  din_s1_q, din_s2_q;
    logic [1:0]  cap_q, cap_d;
    logic [4:0]  setup_cycles;

    assign busy = (state_q != st_idle);

    // overhead first, then the programmed setup, counted down to zero
    assign setup_cycles = fixed_overhead[4:0] - one_cycle
                        + {3'b000, timing_q[setup_hi:setup_lo]};

    // latch phase width in clocks: the two-bit field plus one
    function automatic logic [4:0] width_of(input logic [1:0] f);
        return {3'b000, f} + one_cycle;
    endfunction

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        req_d   = req_q;
        upper_d = upper_q;
        mux_d   = mux_q;
        addr_d  = addr_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        // read byte reaches the second sync flop two cycles after the last strobe cycle
        cap_d   = {cap_q[0], (state_q == st_strobe) && (cnt_q == 5'h00) && !req_q.is_write};
        unique case (state_q)
            st_idle: begin
                if (move_valid) begin
                    req_d   = move_req;
                    upper_d = drive_upper;
                    mux_d   = multiplexed;
                    addr_d  = eff_addr;
                    cnt_d   = setup_cycles;
                    state_d = go_offchip ? st_setup : st_onchip;
                end
            end
            st_onchip: begin
                rdata_d = ram_rdata;
                done_d  = 1'b1;
                cnt_d   = 5'h00;
                state_d = st_tail;
            end
            st_setup: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - one_cycle;
                end else if (mux_q) begin
                    cnt_d   = width_of(config_q[ale_hi:ale_lo]) - one_cycle;
                    state_d = st_ale_hi;
                end else begin
                    cnt_d   = {1'b0, timing_q[strobe_hi:strobe_lo]};
                    state_d = st_strobe;
                end
            end
            st_ale_hi: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - one_cycle;
                end else begin
                    cnt_d   = width_of(config_q[ale_hi:ale_lo]) - one_cycle;
                    state_d = st_ale_lo;
                end
            end
            st_ale_lo: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - one_cycle;
                end else begin
                    cnt_d   = {1'b0, timing_q[strobe_hi:strobe_lo]};
                    state_d = st_strobe;
                end
            end
            st_strobe: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - one_cycle;
                end else begin
                    cnt_d   = {3'b000, timing_q[hold_hi:hold_lo]};
                    state_d = st_hold;
                end
            end
            st_hold: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - one_cycle;
                end else begin
                    // one extra cycle so the synchronised read byte is captured
                    cnt_d   = one_cycle;
                    state_d = st_tail;
                end
            end
            st_tail: begin
                if (cnt_q != 5'h00) begin
                    cnt_d  = cnt_q - one_cycle;
                    done_d = 1'b1;
                end else begin
                    state_d = st_idle;
                end
            end
            default: state_d = st_idle;
        endcase
        if (cap_q[1]) begin
            rdata_d = din_s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= st_idle;
            cnt_q    <= 5'h00;
            req_q    <= '0;
            upper_q  <= 1'b0;
            mux_q    <= 1'b0;
            addr_q   <= 16'h0000;
            rdata_q  <= 8'h00;
            done_q   <= 1'b0;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            cap_q    <= 2'b00;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            req_q    <= req_d;
            upper_q  <= upper_d;
            mux_q    <= mux_d;
            addr_q   <= addr_d;
            rdata_q  <= rdata_d;
            done_q   <= done_d;
            din_s1_q <= ext_data_in;
            din_s2_q <= din_s1_q;
            cap_q    <= cap_d;
        end
    end

    assign move_done  = done_q;
    assign move_rdata = rdata_q;

    // ************************************************************
    // on-chip ram and pin drive
    // ************************************************************
    logic offchip_active;
    // tail holds move_done only, so the pins are already back with the port latches
    assign offchip_active = (state_q != st_idle) && (state_q != st_onchip)
                            && (state_q != st_tail);

    assign ram_en    = (state_q == st_idle) && move_valid && !go_offchip;
    assign ram_we    = ram_en && move_req.is_write;
    assign ram_addr  = eff_addr[onchip_addr_bits-1:0];
    assign ram_wdata = move_req.wdata;

    always_comb begin
        pins          = '0;
        pins.rd_b     = 1'b1;
        pins.wr_b     = 1'b1;
        if (offchip_active) begin
            pins.ctrl_oe  = 1'b1;
            pins.addr_out = addr_q;
            pins.addr_oe  = {{8{upper_q}}, {8{!mux_q}}};
            pins.ale      = (state_q == st_ale_hi);
            if (mux_q && (state_q == st_setup || state_q == st_ale_hi)) begin
                pins.data_out = addr_q[7:0];
                pins.data_oe  = 1'b1;
            end else begin
                pins.data_out = req_q.wdata;
                pins.data_oe  = req_q.is_write && (state_q != st_setup);
            end
            pins.rd_b = !((state_q == st_strobe) && !req_q.is_write);
            pins.wr_b = !((state_q == st_strobe) && req_q.is_write);
        end
    end

endmodule

`default_nettype wire

// ==== xmem_monitor.sv ====
/* checker for the external data move router: strobe, latch and claim timing at the pins.
   assumes the timing and configuration registers change only through ahb-lite writes. */
`timescale 1ns/10ps
`default_nettype none
module xmem_monitor
    import xmem_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        move_done,
    input wire logic        ram_en,
    input wire ext_pins_t   pins
);
    // ********
    // shadow registers and run counters
    // ********
    logic       wv_q;
    logic       seen_q;
    logic       stb;
    logic [7:0] wa_q, tc_q, stb_q, pre_q, ale_q, exp_pre;
    logic [5:0] cf_q;
    assign stb = !pins.rd_b || !pins.wr_b;
    assign exp_pre = {6'h00, tc_q[7:6]} + 8'h04
                   + (cf_q[mux_select_bit] ? 8'h00 : {5'h00, cf_q[1:0], 1'b0} + 8'h02);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wv_q   <= 1'b0;
            wa_q   <= 8'h00;
            tc_q   <= timing_ctrl_reset;
            cf_q   <= config_reset;
            stb_q  <= 8'h00;
            pre_q  <= 8'h00;
            ale_q  <= 8'h00;
            seen_q <= 1'b0;
        end else begin
            wv_q   <= hsel && hready && htrans[1] && hwrite;
            wa_q   <= haddr[7:0];
            if (wv_q && wa_q == timing_ctrl_addr) tc_q <= hwdata[7:0];
            if (wv_q && wa_q == config_addr) cf_q <= hwdata[5:0];
            stb_q  <= stb ? stb_q + 8'h01 : 8'h00;
            ale_q  <= pins.ale ? ale_q + 8'h01 : 8'h00;
            seen_q <= pins.ctrl_oe && (seen_q || stb);
            pre_q  <= !pins.ctrl_oe ? 8'h00 : (!seen_q && !stb ? pre_q + 8'h01 : pre_q);
        end
    end
    // ********
    // assertions
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence quiet_s;
        !pins.ctrl_oe && !pins.ale && !stb;
    endsequence
    a_strobe_width: assert property ($fell(stb) |-> stb_q == {4'h0, tc_q[5:2]} + 8'h01)
        else $error("strobe width differs from timing field");
    a_setup_span: assert property ($rose(stb) |-> pre_q == exp_pre)
        else $error("cycles before strobe differ from setup plus overhead");
    a_ale_width: assert property ($fell(pins.ale) |-> ale_q == {6'h00, cf_q[1:0]} + 8'h01)
        else $error("latch enable high width wrong");
    a_ale_mux_only: assert property (pins.ale |-> !cf_q[mux_select_bit])
        else $error("latch enable in non-multiplexed mode");
    a_ale_drives_low: assert property (pins.ale |-> pins.data_oe && pins.ctrl_oe)
        else $error("low address not on data pins while latch enable high");
    a_strobe_claimed: assert property (stb |-> pins.ctrl_oe)
        else $error("strobe without pins claimed");
    a_onchip_quiet: assert property (ram_en |-> quiet_s [*3])
        else $error("on-chip move touched the external pins");
    a_release_done: assert property (move_done |-> ##[0:1] !pins.ctrl_oe)
        else $error("pins still claimed after move completed");
    a_done_pulse: assert property (move_done |=> !move_done)
        else $error("move done longer than one cycle");
endmodule
bind xmem_ctrl xmem_monitor mon (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .move_done(move_done), .ram_en(ram_en), .pins(pins));
`default_nettype wire

// ==== ext_sram_model.sv ====
/* asynchronous external byte memory on the off-chip pins, with an address latch.
   assumes undriven address lines sit at the parked high port level. */
`timescale 1ns/10ps
`default_nettype none
module ext_sram_model
    import xmem_pkg::*;
(
    input wire logic  clk,
    input wire ext_pins_t pins,
    output logic [7:0] ext_data_in
);
    // ********
    // address decode and storage
    // ********
    logic [7:0]  mem [65536];
    logic [7:0]  lat_q;
    logic [7:0]  last_q;
    logic [15:0] eff;
    logic [15:0] last_addr;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            eff[i] = pins.addr_oe[i] ? pins.addr_out[i] : 1'b1;
        end
        if (pins.addr_oe[7:0] == 8'h00) eff[7:0] = lat_q;
    end
    // released data bus toggles so a late sample cannot pass by chance
    assign ext_data_in = (pins.ctrl_oe && !pins.rd_b) ? mem[eff] : ~last_q;
    always @(posedge clk) begin
        last_q <= ext_data_in;
        if (pins.ale) lat_q <= pins.data_out;
        if (pins.ctrl_oe && !pins.wr_b) mem[eff] <= pins.data_out;
        if (pins.ctrl_oe && !(pins.wr_b && pins.rd_b)) last_addr <= eff;
    end
endmodule
`default_nettype wire

// ==== ext_data_mem_mode_and_timing_tb_top.sv ====
/* testbench for xmem_ctrl: register access, mode routing and address drive per pass.
   assumes a zero-wait ahb-lite slave and a one-cycle synchronous on-chip ram. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module ext_data_mem_mode_and_timing_tb_top;
    import xmem_pkg::*;
    logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic        move_valid, move_done, ram_en, ram_we, ext;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  move_rdata, ram_wdata, ram_rdata, ext_data_in, rd;
    logic [11:0] ram_addr;
    logic [15:0] ea;
    logic [16:0] ex;
    logic [7:0]  oram [4096];
    move_req_t   move_req;
    ext_pins_t   pins;
    int          fails = 0, compares = 0, cyc = 0;
    logic [7:0]  tc_tab [3] = '{8'hFF, 8'h4E, 8'h00};
    logic [15:0] dp_tab [3] = '{16'h1234, 16'h0345, 16'h0067};
    logic [7:0]  ra_tab [4] = '{timing_ctrl_addr, config_addr, page_select_addr, 8'h10};
    logic [7:0]  rr_tab [4] = '{timing_ctrl_reset, {2'b00, config_reset}, page_select_reset, 8'h00};
    assign hready = hreadyout;
    xmem_ctrl uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .move_valid(move_valid), .move_req(move_req),
        .move_done(move_done), .move_rdata(move_rdata), .ram_en(ram_en), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .pins(pins),
        .ext_data_in(ext_data_in));
    ext_sram_model mdl (.clk(clk), .pins(pins), .ext_data_in(ext_data_in));
    // ********
    // clock, on-chip ram, timeout
    // ********
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ram_en && ram_we) oram[ram_addr] <= ram_wdata;
        ram_rdata <= oram[ram_addr];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    // ********
    // bus and move tasks
    // ********
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rv = hrdata;
        `CHK("response", 1'b0, hresp)
    endtask
    task automatic mv(input logic w, input logic wide, input logic [15:0] dp, input logic [7:0] d);
        move_valid <= 1'b1;
        move_req   <= '{w, wide, dp, dp[7:0], d};
        ext = 1'b0;
        ea  = 16'h0000;
        do begin
            @(posedge clk);
            if (pins.ctrl_oe === 1'b1) ext = 1'b1;
            if (ram_en === 1'b1) ea = {4'h0, ram_addr};
        end while (move_done !== 1'b1);
        rd = move_rdata;
        move_valid <= 1'b0;
        if (ext) ea = mdl.last_addr;
        @(posedge clk);
    endtask
    function automatic logic [16:0] expect_of(int m, int c);
        case (c)
            0: return m == 0 ? 17'h0_0234 : 17'h1_1234;
            1: return m == 3 ? 17'h1_0345 : 17'h0_0345;
            default: return m == 0 ? 17'h0_0567 : (m == 2 ? 17'h1_2567 : 17'h1_FF67);
        endcase
    endfunction
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        move_valid = 1'b0;
        move_req = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b1, 8'h10, 32'h0000_00AA);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, ra_tab[i], 32'h0000_0000);
            `CHK("reset value", {24'h00_0000, rr_tab[i]}, rv)
        end
        bus(1'b1, page_select_addr, 32'h0000_0025);
        for (int p = 0; p < 3; p++) begin
            bus(1'b1, timing_ctrl_addr, {24'h00_0000, tc_tab[p]});
            bus(1'b0, timing_ctrl_addr, 32'h0000_0000);
            `CHK("timing", {24'h00_0000, tc_tab[p]}, rv)
            for (int m = 0; m < 4; m++) begin
                bus(1'b1, config_addr, {27'h000_0000, p == 0, 2'(m), 1'b0, p == 1});
                for (int c = 0; c < 3; c++) begin
                    ex = expect_of(m, c);
                    mv(1'b1, c < 2, dp_tab[c], 8'(16 * m + c + p));
                    `CHK("off-chip", ex[16], ext)
                    `CHK("address", ex[15:0], ea)
                    mv(1'b0, c < 2, dp_tab[c], 8'h00);
                    `CHK("read back", 8'(16 * m + c + p), rd)
                end
            end
        end
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire
